// >>> rtl/seeprm_pkg.sv
// Purpose: shared constants and types for the two-wire eeprom slave
// Assumes: 20 MHz system clock
// Notes: memory depth fixed at the larger capacity
package seeprm_pkg;
  localparam logic [3:0] DEV_TYPE_CODE = 4'h5; // arbitrary value
  localparam int CLK_HZ = 20000000;
  localparam int INTERNAL_WRITE_TIME_US = 10000;
  localparam int WRITE_CYCLES = INTERNAL_WRITE_TIME_US * (CLK_HZ / 1000000);
  localparam int MEM_BYTES = 32768;
  localparam int ADDR_W = 15;
  localparam int PAGE_BYTES = 64;
  localparam int PAGE_W = 6;
  localparam int FIFO_DEPTH = 16;
  localparam int DATA_W = 8;
  // one-cycle glitch rejection; longer lag lets our own sda edge
  // land after the filtered scl rise and read as a false start
  localparam logic [3:0] FILT_MAX = 4'h1;

  typedef enum {
    SEE_IDLE, SEE_DEVADR, SEE_ADRHI, SEE_ADRLO, SEE_WDATA, SEE_RDATA,
    SEE_MACK, SEE_SKIP, SEE_PROG
  } seeprm_state_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } seeprm_wr_t;

  typedef struct packed {
    logic sda_i;
    logic sda_o;
    logic sda_oe;
  } seeprm_sda_t;
endpackage

// >>> rtl/seeprm_fifo.sv
// Purpose: page-buffer fifo between the bus side and the array write
// Assumes: single clock
// Notes: width and depth are parameters
`timescale 1ns/1ps
module seeprm_fifo #(
  parameter int WIDTH = 23,
  parameter int DEPTH = 16
) (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  localparam int PW = $clog2(DEPTH);
  typedef struct packed {
    logic [PW-1:0] wp;
    logic [PW-1:0] rp;
    logic [PW:0] cnt;
  } seeprm_fifo_st_t;
  seeprm_fifo_st_t st_ff, nxt_st;
  logic [WIDTH-1:0] mem [DEPTH];
  logic push, pop;

  assign push = i_in_valid && o_in_ready;
  assign pop = o_out_valid && i_out_ready;
  assign o_in_ready = (st_ff.cnt != (PW+1)'(DEPTH));
  assign o_out_valid = (st_ff.cnt != '0);
  assign o_out_data = mem[st_ff.rp];

  always_comb begin
    nxt_st = st_ff;
    if (push) nxt_st.wp = st_ff.wp + 1'b1;
    if (pop) nxt_st.rp = st_ff.rp + 1'b1;
    nxt_st.cnt = st_ff.cnt + (PW+1)'(push) - (PW+1)'(pop);
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) st_ff <= '0;
    else st_ff <= nxt_st;
    if (push) mem[st_ff.wp] <= i_in_data;
  end
endmodule

// >>> rtl/seeprm_top.sv
// Purpose: two-wire serial eeprom slave with page write and sequential read
// Assumes: scl/sda/straps/wp asynchronous, sampled at 20 MHz
// Notes: a 64-byte page wraps in place; fifo holds 16 bytes and drains at once
`timescale 1ns/1ps
module seeprm_top
  import seeprm_pkg::*;
(
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic [2:0] i_addr_strap_pins,
  input wire logic i_wp,
  output logic o_sda,
  output logic o_sda_oe,
  output logic o_busy
);
  import seeprm_pkg::*;

  // ==========================================================
  // state
  typedef struct packed {
    logic [1:0] scl_s;
    logic [1:0] sda_s;
    logic [2:0] strap_s0;
    logic [2:0] strap_s1;
    logic [1:0] wp_s;
    logic [3:0] scl_cnt;
    logic [3:0] sda_cnt;
    logic scl_f;
    logic sda_f;
    seeprm_state_t st;
    logic [3:0] bitn;
    logic [7:0] sh;
    logic [7:0] adr_hi;
    logic [ADDR_W-1:0] ctr;
    logic [ADDR_W-1:0] wbase;
    logic [PAGE_W:0] nbytes;
    logic sda_oe;
    logic busy;
    logic [23:0] tmr;
  } seeprm_st_t;

  seeprm_st_t st_ff, nxt_st;
  logic [DATA_W-1:0] mem [MEM_BYTES];
  logic [DATA_W-1:0] rd_byte;
  logic scl_rise, scl_fall, start_c, stop_c;
  logic f_in_valid, f_in_ready, f_out_valid, f_out_ready;
  seeprm_wr_t f_in, f_out;

  function automatic logic [ADDR_W-1:0] page_inc(
    input logic [ADDR_W-1:0] a
  );
    page_inc = {a[ADDR_W-1:PAGE_W], a[PAGE_W-1:0] + 1'b1};
  endfunction

  function automatic logic [3:0] filt(input logic [3:0] c,
                                      input logic same);
    if (same) filt = 4'h0;
    else filt = c + 4'h1;
  endfunction

  // ==========================================================
  // edge and condition detect
  assign scl_rise = (nxt_st.scl_f && !st_ff.scl_f);
  assign scl_fall = (!nxt_st.scl_f && st_ff.scl_f);
  assign start_c = st_ff.scl_f && st_ff.sda_f && !nxt_st.sda_f;
  assign stop_c = st_ff.scl_f && !st_ff.sda_f && nxt_st.sda_f;
  assign rd_byte = mem[st_ff.ctr];

  // ==========================================================
  // page buffer
  seeprm_fifo #(.WIDTH(ADDR_W + DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
    .i_clk(i_clk),
    .i_reset_n(i_reset_n),
    .i_in_valid(f_in_valid),
    .o_in_ready(f_in_ready),
    .i_in_data(f_in),
    .o_out_valid(f_out_valid),
    .i_out_ready(f_out_ready),
    .o_out_data(f_out)
  );
  // always drains; array write only when write allowed
  assign f_out_ready = 1'b1;
  assign f_in = '{addr: st_ff.wbase, data: st_ff.sh};

  always_ff @(posedge i_clk) begin
    if (f_out_valid && !st_ff.wp_s[1]) begin
      mem[f_out.addr] <= f_out.data;
    end
  end

  // ==========================================================
  // control
  always_comb begin
    nxt_st = st_ff;
    f_in_valid = 1'b0;
    nxt_st.scl_s = {st_ff.scl_s[0], i_scl};
    nxt_st.sda_s = {st_ff.sda_s[0], i_sda};
    nxt_st.strap_s0 = i_addr_strap_pins;
    nxt_st.strap_s1 = st_ff.strap_s0;
    nxt_st.wp_s = {st_ff.wp_s[0], i_wp};
    nxt_st.scl_cnt = filt(st_ff.scl_cnt, st_ff.scl_s[1] == st_ff.scl_f);
    nxt_st.sda_cnt = filt(st_ff.sda_cnt, st_ff.sda_s[1] == st_ff.sda_f);
    if (st_ff.scl_cnt >= FILT_MAX) begin
      nxt_st.scl_f = st_ff.scl_s[1];
      nxt_st.scl_cnt = 4'h0;
    end
    if (st_ff.sda_cnt >= FILT_MAX) begin
      nxt_st.sda_f = st_ff.sda_s[1];
      nxt_st.sda_cnt = 4'h0;
    end
    if (st_ff.st == SEE_PROG) begin
      // inputs ignored while programming
      if (st_ff.tmr == '0) begin
        nxt_st.st = SEE_IDLE;
        nxt_st.busy = 1'b0;
      end else begin
        nxt_st.tmr = st_ff.tmr - 24'h1;
      end
    end else if (stop_c) begin
      nxt_st.sda_oe = 1'b0;
      nxt_st.st = SEE_IDLE;
      // stop lands in the clock after the ack, one bit shifted in
      if (st_ff.st == SEE_WDATA && st_ff.bitn <= 4'h1 &&
          st_ff.nbytes != '0 && !st_ff.wp_s[1]) begin
        nxt_st.st = SEE_PROG;
        nxt_st.busy = 1'b1;
        nxt_st.tmr = 24'(WRITE_CYCLES - 1);
      end
    end else if (start_c) begin
      nxt_st.st = SEE_DEVADR;
      nxt_st.bitn = 4'h0;
      nxt_st.sda_oe = 1'b0;
    end else begin
      case (st_ff.st)
        SEE_IDLE, SEE_SKIP: begin
          nxt_st.sda_oe = 1'b0;
        end
        SEE_DEVADR, SEE_ADRHI, SEE_ADRLO, SEE_WDATA: begin
          if (scl_rise && st_ff.bitn < 4'h8) begin
            nxt_st.sh = {st_ff.sh[6:0], st_ff.sda_f};
            nxt_st.bitn = st_ff.bitn + 4'h1;
          end else if (scl_fall && st_ff.bitn == 4'h8) begin
            nxt_st.bitn = 4'h9;
            nxt_st.sda_oe = 1'b1;
            case (st_ff.st)
              SEE_DEVADR: begin
                if (st_ff.sh[7:1] != {DEV_TYPE_CODE, st_ff.strap_s1}) begin
                  nxt_st.sda_oe = 1'b0;
                  nxt_st.st = SEE_SKIP;
                end
              end
              SEE_WDATA: begin
                if (!f_in_ready) nxt_st.sda_oe = 1'b0; // buffer full
                else begin
                  f_in_valid = 1'b1;
                  nxt_st.nbytes = st_ff.nbytes + 1'b1;
                end
              end
              default: begin
              end
            endcase
          end else if (scl_fall && st_ff.bitn == 4'h9) begin
            nxt_st.sda_oe = 1'b0;
            nxt_st.bitn = 4'h0;
            if (!st_ff.sda_oe) nxt_st.st = SEE_SKIP;
            else begin
              case (st_ff.st)
                SEE_DEVADR: begin
                  if (st_ff.sh[0]) begin
                    nxt_st.st = SEE_RDATA;
                    nxt_st.sda_oe = !rd_byte[7];
                    nxt_st.sh = {rd_byte[6:0], 1'b1};
                    nxt_st.bitn = 4'h1;
                  end else begin
                    nxt_st.st = SEE_ADRHI;
                  end
                end
                SEE_ADRHI: begin
                  nxt_st.adr_hi = st_ff.sh;
                  nxt_st.st = SEE_ADRLO;
                end
                SEE_ADRLO: begin
                  nxt_st.ctr = {st_ff.adr_hi[ADDR_W-9:0], st_ff.sh};
                  nxt_st.wbase = {st_ff.adr_hi[ADDR_W-9:0], st_ff.sh};
                  nxt_st.nbytes = '0;
                  nxt_st.st = SEE_WDATA;
                end
                default: begin
                  nxt_st.wbase = page_inc(st_ff.wbase);
                  nxt_st.ctr = page_inc(st_ff.wbase);
                end
              endcase
            end
          end
        end
        SEE_RDATA: begin
          if (scl_fall) begin
            if (st_ff.bitn < 4'h8) begin
              nxt_st.sda_oe = !st_ff.sh[7];
              nxt_st.sh = {st_ff.sh[6:0], 1'b1};
              nxt_st.bitn = st_ff.bitn + 4'h1;
            end else begin
              nxt_st.sda_oe = 1'b0;
              nxt_st.ctr = st_ff.ctr + 1'b1;
              nxt_st.st = SEE_MACK;
            end
          end
        end
        SEE_MACK: begin
          if (scl_rise) begin
            nxt_st.bitn = st_ff.sda_f ? 4'hF : 4'h0;
          end else if (scl_fall) begin
            if (st_ff.bitn == 4'hF) nxt_st.st = SEE_SKIP;
            else begin
              nxt_st.st = SEE_RDATA;
              nxt_st.sda_oe = !rd_byte[7];
              nxt_st.sh = {rd_byte[6:0], 1'b1};
              nxt_st.bitn = 4'h1;
            end
          end
        end
        default: begin
          nxt_st.st = SEE_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_reset_n) begin
      st_ff <= '0;
      st_ff.scl_s <= 2'h3;
      st_ff.sda_s <= 2'h3;
      st_ff.scl_f <= 1'b1;
      st_ff.sda_f <= 1'b1;
      st_ff.st <= SEE_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  assign o_sda = 1'b0;
  assign o_sda_oe = st_ff.sda_oe;
  assign o_busy = st_ff.busy;
endmodule

// >>> sim/seeprm_assertions.sv
// Purpose: port checks for the two-wire eeprom slave
// Assumes: sees top ports only
// Notes: bind statement at the foot
`timescale 1ns/1ps
module seeprm_chk (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_scl,
  input wire logic i_sda,
  input wire logic [2:0] i_addr_strap_pins,
  input wire logic i_wp,
  input wire logic o_sda,
  input wire logic o_sda_oe,
  input wire logic o_busy
);
  // ==========
  // sequences
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);
  sequence s_pull;
    o_sda_oe[*6];
  endsequence
  sequence s_prog;
    (o_busy && !o_sda_oe)[*8];
  endsequence
  // ==========
  // properties
  a_open_drain: assert property (o_sda == 1'b0)
    else $error("sda output not low");
  a_busy_no_ack: assert property (o_busy |-> !o_sda_oe)
    else $error("pull while programming");
  a_wp_blocks: assert property ($rose(o_busy) |-> !i_wp)
    else $error("program started under write protect");
  a_wp_idle: assert property (i_wp && !o_busy |=> !o_busy)
    else $error("busy rose with write protect");
  a_busy_holds: assert property ($rose(o_busy) |=> s_prog)
    else $error("program cycle cut short");
  a_busy_on_stop: assert property ($rose(o_busy) |-> i_scl && i_sda)
    else $error("program began without stop");
  a_ack_width: assert property ($rose(o_sda_oe) |=> s_pull)
    else $error("pull shorter than a bit");
  a_idle_release: assert property ((i_scl && i_sda)[*8] |-> !o_sda_oe)
    else $error("pull on idle bus");
endmodule

bind seeprm_top seeprm_chk u_chk (
  .i_clk(i_clk), .i_reset_n(i_reset_n), .i_scl(i_scl), .i_sda(i_sda),
  .i_addr_strap_pins(i_addr_strap_pins), .i_wp(i_wp), .o_sda(o_sda),
  .o_sda_oe(o_sda_oe), .o_busy(o_busy));

// >>> sim/seeprm_master.sv
// Purpose: two-wire bus master model driving clock and data
// Assumes: pull-up on data, released level reads high
// Notes: clock stands high outside frames
`timescale 1ns/1ps
module seeprm_master (
  input wire logic i_clk,
  input wire logic i_sda,
  output logic o_scl,
  output logic o_sda_rel,
  output logic o_ack_v,
  output logic o_ack,
  output logic o_rd_v,
  output logic [7:0] o_rd_byte
);
  initial begin
    o_scl = 1'b1;
    o_sda_rel = 1'b1;
    o_ack_v = 1'b0;
    o_ack = 1'b0;
    o_rd_v = 1'b0;
    o_rd_byte = 8'h00;
  end
  task automatic q(input int n);
    repeat (n) @(posedge i_clk);
    #1;
  endtask
  task automatic start_c();
    q(2);
    o_sda_rel = 1'b1;
    q(2);
    o_scl = 1'b1;
    q(4);
    o_sda_rel = 1'b0;
    q(4);
    o_scl = 1'b0;
  endtask
  task automatic stop_c();
    q(2);
    o_sda_rel = 1'b0;
    q(2);
    o_scl = 1'b1;
    q(4);
    o_sda_rel = 1'b1;
    q(8);
  endtask
  // nine clocks a byte, ninth carries the ack
  task automatic xfer(input logic [7:0] d, input logic rd, input logic mack);
    for (int i = 7; i >= -1; i--) begin
      q(2);
      o_sda_rel = (i < 0) ? (rd ? mack : 1'b1) : (rd | d[i]);
      q(2);
      o_scl = 1'b1;
      q(4);
      o_ack = i_sda;
      if (i >= 0) o_rd_byte = {o_rd_byte[6:0], i_sda};
      o_ack_v = (i < 0) & ~rd;
      o_rd_v = (i < 0) & rd;
      o_scl = 1'b0;
    end
    q(1);
    o_ack_v = 1'b0;
    o_rd_v = 1'b0;
  endtask
endmodule

// >>> sim/test_seeprm_top.sv
// Purpose: self-checking bench for the two-wire eeprom slave
// Assumes: 50 ns clock, bus clock 400 ns
// Notes: one long program cycle is started, not waited out
`timescale 1ns/1ps
module test_seeprm_top;
  import seeprm_pkg::*;
  logic i_clk, i_reset_n, i_wp, o_sda, o_sda_oe, o_busy, scl, rel, ack_v, ack;
  logic [2:0] straps;
  logic [31:0] lfsr_ff = 32'h1F2A;
  logic [7:0] v, rbyte;
  logic rd_v;
  logic exp_q[$];
  logic [7:0] exp_d[$];
  int mismatches, comparisons, cyc;
  wire sda = rel & ~o_sda_oe;
  seeprm_top u_dut (.i_clk(i_clk), .i_reset_n(i_reset_n), .i_scl(scl),
    .i_sda(sda), .i_addr_strap_pins(straps), .i_wp(i_wp), .o_sda(o_sda),
    .o_sda_oe(o_sda_oe), .o_busy(o_busy));
  seeprm_master u_mst (.i_clk(i_clk), .i_sda(sda), .o_scl(scl),
    .o_sda_rel(rel), .o_ack_v(ack_v), .o_ack(ack), .o_rd_v(rd_v),
    .o_rd_byte(rbyte));
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  initial begin
    i_clk = 1'b0;
    forever #25 i_clk = ~i_clk;
  end
  // ==========
  // tasks
  task automatic cmp_ack(input logic g, input logic e);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %0t ack level wrong", $time);
    end
  endtask
  task automatic cmp_bit(input logic g, input logic e);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %0t output level wrong", $time);
    end
  endtask
  task automatic cmp_data(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      mismatches++;
      $display("ERROR %0t read data wrong", $time);
    end
  endtask
  task automatic end_sim();
    if (mismatches == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic wb(input logic [7:0] d, input logic e);
    exp_q.push_back(e);
    u_mst.xfer(d, 1'b0, 1'b0);
  endtask
  // address, two address bytes, three data bytes
  task automatic page(input logic [7:0] hi, input logic [7:0] lo);
    u_mst.start_c();
    wb({DEV_TYPE_CODE, straps, 1'b0}, 1'b0);
    wb(hi, 1'b0);
    wb(lo, 1'b0);
    for (int i = 0; i < 3; i++) begin
      lfsr_ff = lfsr_next(lfsr_ff);
      exp_d.push_back(lfsr_ff[7:0]);
      wb(lfsr_ff[7:0], 1'b0);
    end
    u_mst.stop_c();
  endtask
  // ==========
  // result watcher and timeout
  always @(posedge i_clk) begin
    cyc++;
    if (ack_v === 1'b1 && exp_q.size() > 0)
      cmp_ack(ack, exp_q.pop_front());
    if (rd_v === 1'b1 && exp_d.size() > 0)
      cmp_data(rbyte, exp_d.pop_front());
    if (cyc == 20000) begin
      mismatches++;
      end_sim();
    end
  end
  // ==========
  // main sequence
  initial begin
    i_reset_n = 1'b0;
    i_wp = 1'b1;
    straps = lfsr_ff[2:0];
    repeat (12) @(posedge i_clk);
    #1;
    i_reset_n = 1'b1;
    u_mst.q(10);
    u_mst.start_c();
    wb({DEV_TYPE_CODE, ~straps, 1'b0}, 1'b1);
    u_mst.stop_c();
    page(8'h12, 8'h10);
    cmp_bit(o_busy, 1'b0);
    exp_d.delete();
    straps = 3'h0;
    i_wp = 1'b0;
    page(8'h12, 8'h10);
    u_mst.q(10);
    cmp_bit(o_busy, 1'b1);
    u_mst.start_c();
    wb({DEV_TYPE_CODE, straps, 1'b0}, 1'b1);
    u_mst.stop_c();
    // reset cuts the long program cycle; the array keeps its bytes
    i_reset_n = 1'b0;
    u_mst.q(12);
    i_reset_n = 1'b1;
    u_mst.q(10);
    u_mst.start_c();
    wb({DEV_TYPE_CODE, 3'h0, 1'b0}, 1'b0);
    wb(8'h12, 1'b0);
    wb(8'h10, 1'b0);
    u_mst.stop_c();
    cmp_bit(o_busy, 1'b0);
    u_mst.start_c();
    wb({DEV_TYPE_CODE, 3'h0, 1'b1}, 1'b0);
    u_mst.xfer(8'hFF, 1'b1, 1'b0);
    u_mst.xfer(8'hFF, 1'b1, 1'b1);
    u_mst.stop_c();
    cmp_bit(o_sda_oe, 1'b0);
    u_mst.q(20);
    end_sim();
  end
endmodule
